//--- include/glitchfree_clock_mux_defs.svh
`ifndef GLITCHFREE_CLOCK_MUX_DEFS_SVH
`define GLITCHFREE_CLOCK_MUX_DEFS_SVH

// Number of complementary output pairs.
`define GF_NUM_PAIRS 5
// Reset values of the output legs and the gate.
`define GF_TRUE_RST 1'b0
`define GF_COMP_RST 1'b1
`define GF_GATE_RST 1'b0
// Reset value of the enable synchroniser stages.
`define GF_SYNC_RST 1'b0
// Levels taken by undriven control inputs.
`define GF_SEL_DEFAULT 1'b0
`define GF_EN_DEFAULT 1'b1
// Cycles an enable change needs to cross the synchroniser.
`define GF_SYNC_CYCLES 2

`endif

//--- include/glitchfree_clock_mux_pkg.sv
package glitchfree_clock_mux_pkg;

   // Gate sequencer states, Gray coded along steady, wait rise, wait fall.
   typedef enum logic [1:0] {
      GATE_STEADY = 2'b00,
      GATE_WAIT_RISE = 2'b01,
      GATE_WAIT_FALL = 2'b11
   } gate_state_e;

endpackage : glitchfree_clock_mux_pkg

//--- logic/gate_sequencer.sv
`timescale 1ns/1ps
`include "glitchfree_clock_mux_defs.svh"

module gate_sequencer (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Output gate enable from the board.
   input wire logic gate_en,
   input wire logic gate_driven,
   // Selected clock level, current and one sample back.
   input wire logic clk_lvl,
   input wire logic clk_prev,
   // Applied gate state.
   output logic gate_on,
   output glitchfree_clock_mux_pkg::gate_state_e gate_state
);
   import glitchfree_clock_mux_pkg::*;

   logic en_eff;
   logic sync1_r;
   logic sync2_r;
   logic gate_r;
   logic gate_nxt;
   gate_state_e state_r;
   gate_state_e state_nxt;
   logic rise;
   logic fall;

   // An undriven enable is taken as high.
   assign en_eff = gate_driven ? gate_en : `GF_EN_DEFAULT;
   assign rise = clk_lvl & ~clk_prev;
   assign fall = ~clk_lvl & clk_prev;

   // Two-stage synchroniser for the asynchronous enable.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= `GF_SYNC_RST;
         sync2_r <= `GF_SYNC_RST;
      end else begin
         sync1_r <= en_eff;
         sync2_r <= sync1_r;
      end
   end

   // A change waits for one rising and then one falling clock edge.
   always_comb begin
      state_nxt = state_r;
      gate_nxt = gate_r;
      case (state_r)
         GATE_STEADY: begin
            if (sync2_r != gate_r) begin
               state_nxt = GATE_WAIT_RISE;
            end
         end
         GATE_WAIT_RISE: begin
            if (sync2_r == gate_r) begin
               state_nxt = GATE_STEADY;
            end else if (rise) begin
               state_nxt = GATE_WAIT_FALL;
            end
         end
         GATE_WAIT_FALL: begin
            if (sync2_r == gate_r) begin
               state_nxt = GATE_STEADY;
            end else if (fall) begin
               gate_nxt = sync2_r;
               state_nxt = GATE_STEADY;
            end
         end
         default: begin
            state_nxt = GATE_STEADY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= GATE_STEADY;
         gate_r <= `GF_GATE_RST;
      end else begin
         state_r <= state_nxt;
         gate_r <= gate_nxt;
      end
   end

   assign gate_on = gate_r;
   assign gate_state = state_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fall_seen;
      state_r == GATE_WAIT_FALL && fall;
   endsequence

   property p_apply_after_fall;
      $changed(gate_r) |-> ($past(state_r) == GATE_WAIT_FALL) && $past(fall);
   endproperty
   a_apply_after_fall: assert property (p_apply_after_fall)
      else $error("Gate changed without a rise then fall.");

   property p_fall_applies;
      s_fall_seen and (sync2_r != gate_r) |=> gate_r == $past(sync2_r);
   endproperty
   a_fall_applies: assert property (p_fall_applies)
      else $error("Gate not applied on the falling edge.");

   property p_sync_delay;
      (en_eff == 1'b1)[*3] |-> sync2_r;
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("Enable did not cross the synchroniser in two cycles.");

   property p_undriven_enable;
      (!gate_driven)[*3] |-> sync2_r;
   endproperty
   a_undriven_enable: assert property (p_undriven_enable)
      else $error("Undriven enable not taken as high.");

endmodule : gate_sequencer

//--- logic/glitchfree_clock_mux_fanout.sv
`timescale 1ns/1ps
`include "glitchfree_clock_mux_defs.svh"

// How it works
// - Select high routes reference B, low A.
// - Gate off: true legs low, complements high.
// - Gate on: outputs follow selected clock, non-inverting.
// - Gate change applies after rise then fall.
// - Enable synchronised; gate changes cause no shortened output pulses.
// - Five pairs share clock and one gate.

module glitchfree_clock_mux_fanout #(
   parameter int NUM_PAIRS = `GF_NUM_PAIRS
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Reference clock A, true and complement legs.
   input wire logic ref_a_true,
   input wire logic ref_a_comp,
   // Reference clock B, true and complement legs.
   input wire logic ref_b_true,
   input wire logic ref_b_comp,
   // Source select and its driven flag.
   input wire logic src_sel,
   input wire logic src_sel_driven,
   // Output gate enable and its driven flag.
   input wire logic gate_en,
   input wire logic gate_en_driven,
   // Fanout output pairs.
   output logic [NUM_PAIRS-1:0] fanout_true,
   output logic [NUM_PAIRS-1:0] fanout_comp,
   // Current gate sequencer state.
   output glitchfree_clock_mux_pkg::gate_state_e gate_state
);
   import glitchfree_clock_mux_pkg::*;

   logic lvl_a_r;
   logic lvl_a_nxt;
   logic lvl_b_r;
   logic lvl_b_nxt;
   logic sel_eff;
   logic clk_lvl;
   logic clk_prev_r;
   logic gate_on;
   logic [NUM_PAIRS-1:0] true_r;
   logic [NUM_PAIRS-1:0] true_nxt;
   logic [NUM_PAIRS-1:0] comp_r;
   logic [NUM_PAIRS-1:0] comp_nxt;

   // Decodes a differential pair; an equal pair keeps the last level.
   function automatic logic ref_level(input logic t, input logic c, input logic hold);
      ref_level = (t != c) ? t : hold;
   endfunction : ref_level

   always_comb begin
      lvl_a_nxt = ref_level(ref_a_true, ref_a_comp, lvl_a_r);
      lvl_b_nxt = ref_level(ref_b_true, ref_b_comp, lvl_b_r);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_a_r <= `GF_TRUE_RST;
         lvl_b_r <= `GF_TRUE_RST;
         clk_prev_r <= `GF_TRUE_RST;
      end else begin
         lvl_a_r <= lvl_a_nxt;
         lvl_b_r <= lvl_b_nxt;
         clk_prev_r <= clk_lvl;
      end
   end

   // An undriven select is taken as low.
   assign sel_eff = src_sel_driven ? src_sel : `GF_SEL_DEFAULT;
   assign clk_lvl = sel_eff ? lvl_b_r : lvl_a_r;

   gate_sequencer u_gate (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .gate_en(gate_en),
      .gate_driven(gate_en_driven),
      .clk_lvl(clk_lvl),
      .clk_prev(clk_prev_r),
      .gate_on(gate_on),
      .gate_state(gate_state)
   );

   // Every pair carries the same gated clock.
   generate
      for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
         always_comb begin
            true_nxt[i] = gate_on & clk_lvl;
            comp_nxt[i] = ~(gate_on & clk_lvl);
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         true_r <= {NUM_PAIRS{`GF_TRUE_RST}};
         comp_r <= {NUM_PAIRS{`GF_COMP_RST}};
      end else begin
         true_r <= true_nxt;
         comp_r <= comp_nxt;
      end
   end

   assign fanout_true = true_r;
   assign fanout_comp = comp_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_sel_b;
      (gate_on && sel_eff) |=> fanout_true[0] == $past(lvl_b_r);
   endproperty
   a_sel_b: assert property (p_sel_b)
      else $error("Select high did not route reference B.");

   property p_sel_a;
      (gate_on && !sel_eff) |=> fanout_true[0] == $past(lvl_a_r);
   endproperty
   a_sel_a: assert property (p_sel_a)
      else $error("Select low did not route reference A.");

   property p_gate_off;
      !gate_on |=> (fanout_true == '0) && (fanout_comp == '1);
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("Disabled outputs not held true low and complement high.");

   property p_follow;
      gate_on |=> (fanout_true[0] == $past(clk_lvl)) && (fanout_comp == ~fanout_true);
   endproperty
   a_follow: assert property (p_follow)
      else $error("Enabled outputs do not follow the selected clock.");

   property p_no_runt;
      $changed(gate_on) |-> !$past(clk_lvl) && !fanout_true[0];
   endproperty
   a_no_runt: assert property (p_no_runt)
      else $error("Gate changed while the clock was high.");

   property p_pairs_equal;
      (fanout_true == {NUM_PAIRS{fanout_true[0]}}) &&
      (fanout_comp == {NUM_PAIRS{fanout_comp[0]}});
   endproperty
   a_pairs_equal: assert property (p_pairs_equal)
      else $error("Output pairs differ.");

   property p_undriven_sel;
      (!src_sel_driven && gate_on) |=> fanout_true[0] == $past(lvl_a_r);
   endproperty
   a_undriven_sel: assert property (p_undriven_sel)
      else $error("Undriven select did not pick reference A.");

   sequence s_rise_in_wait;
      gate_state == GATE_WAIT_RISE && clk_lvl && !clk_prev_r;
   endsequence

   sequence s_fall_in_wait;
      gate_state == GATE_WAIT_FALL && !clk_lvl && clk_prev_r;
   endsequence

   property p_rise_leaves_wait;
      s_rise_in_wait |=> gate_state != GATE_WAIT_RISE;
   endproperty
   a_rise_leaves_wait: assert property (p_rise_leaves_wait)
      else $error("A rise in the first wait state did not move the sequencer on.");

   property p_fall_ends_wait;
      s_fall_in_wait |=> gate_state == GATE_STEADY;
   endproperty
   a_fall_ends_wait: assert property (p_fall_ends_wait)
      else $error("A fall in the second wait state did not end the change.");

   property p_steady_holds_gate;
      gate_state == GATE_STEADY |=> $stable(gate_on);
   endproperty
   a_steady_holds_gate: assert property (p_steady_holds_gate)
      else $error("Gate changed while the sequencer was steady.");

   property p_rise_wait_holds_gate;
      gate_state == GATE_WAIT_RISE |=> $stable(gate_on);
   endproperty
   a_rise_wait_holds_gate: assert property (p_rise_wait_holds_gate)
      else $error("Gate changed before a rising clock edge.");

   property p_no_skip_rise;
      gate_state == GATE_STEADY |=> gate_state != GATE_WAIT_FALL;
   endproperty
   a_no_skip_rise: assert property (p_no_skip_rise)
      else $error("Sequencer skipped the wait for a rising edge.");

   property p_fall_wait_entry;
      $changed(gate_state) && gate_state == GATE_WAIT_FALL |->
         $past(gate_state) == GATE_WAIT_RISE && $past(clk_lvl) && !$past(clk_prev_r);
   endproperty
   a_fall_wait_entry: assert property (p_fall_wait_entry)
      else $error("Second wait state entered without a rising edge.");

   property p_out_falls_low;
      $fell(fanout_true[0]) |-> !$past(clk_lvl);
   endproperty
   a_out_falls_low: assert property (p_out_falls_low)
      else $error("Output fell while the selected clock was high.");

   property p_out_rises_high;
      $rose(fanout_true[0]) |-> $past(clk_lvl) && $past(gate_on);
   endproperty
   a_out_rises_high: assert property (p_out_rises_high)
      else $error("Output rose without an enabled high clock.");

   property p_comp_inverse;
      fanout_comp == ~fanout_true;
   endproperty
   a_comp_inverse: assert property (p_comp_inverse)
      else $error("Complement legs are not the inverse of the true legs.");

   property p_level_a_decode;
      (ref_a_true != ref_a_comp) |=> lvl_a_r == $past(ref_a_true);
   endproperty
   a_level_a_decode: assert property (p_level_a_decode)
      else $error("Reference A level not taken from its true leg.");

   property p_level_b_decode;
      (ref_b_true != ref_b_comp) |=> lvl_b_r == $past(ref_b_true);
   endproperty
   a_level_b_decode: assert property (p_level_b_decode)
      else $error("Reference B level not taken from its true leg.");

endmodule : glitchfree_clock_mux_fanout

//--- tb/ref_clock_source.sv
`timescale 1ns/1ps

module ref_clock_source #(
   parameter int HALF = 2
) (
   // Sampling clock.
   input wire logic sys_clk,
   // Run control and parked level.
   input wire logic run,
   input wire logic park_lvl,
   // Reference legs.
   output logic ref_true,
   output logic ref_comp
);
   int cnt = 0;
   initial ref_true = 1'b0;
   assign ref_comp = ~ref_true;
   // The source toggles freely, with no regard to the board's gate control.
   always @(posedge sys_clk) begin
      if (!run) begin
         ref_true <= park_lvl;
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         ref_true <= ~ref_true;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : ref_clock_source

//--- tb/glitchfree_clock_mux_fanout_tb_top.sv
`timescale 1ns/1ps
`define CHK(w, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", w, e, g); end end

module glitchfree_clock_mux_fanout_tb_top;
   import glitchfree_clock_mux_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic src_sel = 1'b0;
   logic src_sel_driven = 1'b1;
   logic gate_en = 1'b0;
   logic gate_en_driven = 1'b0;
   logic run_a = 1'b1;
   logic run_b = 1'b1;
   logic park_a = 1'b0;
   logic park_b = 1'b0;
   logic a_t, a_c, b_t, b_c;
   logic [4:0] fanout_true;
   logic [4:0] fanout_comp;
   gate_state_e gate_state;
   int mismatches = 0;
   int num_checks = 0;

   ref_clock_source #(.HALF(2)) i_src_a (.sys_clk(sys_clk), .run(run_a),
      .park_lvl(park_a), .ref_true(a_t), .ref_comp(a_c));
   ref_clock_source #(.HALF(3)) i_src_b (.sys_clk(sys_clk), .run(run_b),
      .park_lvl(park_b), .ref_true(b_t), .ref_comp(b_c));
   glitchfree_clock_mux_fanout #(.NUM_PAIRS(5)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .ref_a_true(a_t), .ref_a_comp(a_c), .ref_b_true(b_t), .ref_b_comp(b_c),
      .src_sel(src_sel), .src_sel_driven(src_sel_driven), .gate_en(gate_en),
      .gate_en_driven(gate_en_driven), .fanout_true(fanout_true),
      .fanout_comp(fanout_comp), .gate_state(gate_state));

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic wait_true(input logic [4:0] e);
      #1;
      for (int i = 0; i < 40 && fanout_true !== e; i++) cyc(1);
      if (fanout_true !== e) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_true

   task automatic pairs(input logic [4:0] e);
      `CHK("fanout_true", e, fanout_true)
      `CHK("fanout_comp", ~e, fanout_comp)
   endtask : pairs

   task automatic first_pulse(input int w);
      int n = 0;
      wait_true(5'h1F);
      while (fanout_true === 5'h1F && n < 40) begin
         n++;
         cyc(1);
      end
      `CHK("pulse width", w, n)
   endtask : first_pulse

   task automatic t_enable();
      first_pulse(2);
      cyc(1);
      pairs(5'h00);
      wait_true(5'h1F);
      pairs(5'h1F);
   endtask : t_enable

   task automatic t_select();
      logic [2:0] tab [3] = '{3'b100, 3'b111, 3'b010};
      @(posedge sys_clk);
      run_a <= 1'b0;
      run_b <= 1'b0;
      park_b <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         src_sel_driven <= tab[i][2];
         src_sel <= tab[i][1];
         cyc(4);
         pairs({5{tab[i][0]}});
      end
   endtask : t_select

   task automatic t_disable();
      @(posedge sys_clk);
      src_sel_driven <= 1'b1;
      gate_en_driven <= 1'b1;
      gate_en <= 1'b0;
      cyc(8);
      pairs(5'h1F);
      `CHK("gate_state", GATE_WAIT_RISE, gate_state)
      @(posedge sys_clk);
      run_b <= 1'b1;
      wait_true(5'h00);
      cyc(10);
      pairs(5'h00);
      @(posedge sys_clk);
      gate_en <= 1'b1;
      first_pulse(3);
   endtask : t_disable

   task automatic t_revert();
      @(posedge sys_clk);
      run_b <= 1'b0;
      cyc(4);
      pairs(5'h1F);
      @(posedge sys_clk);
      gate_en <= 1'b0;
      cyc(6);
      `CHK("gate_state", GATE_WAIT_RISE, gate_state)
      @(posedge sys_clk);
      gate_en <= 1'b1;
      cyc(4);
      `CHK("gate_state", GATE_STEADY, gate_state)
      @(posedge sys_clk);
      run_b <= 1'b1;
      wait_true(5'h00);
      first_pulse(3);
      first_pulse(3);
   endtask : t_revert

   initial begin
      cyc(1);
      pairs(5'h00);
      `CHK("gate_state", GATE_STEADY, gate_state)
      @(posedge sys_clk);
      rst_n <= 1'b1;
      t_enable();
      t_select();
      t_disable();
      t_revert();
      stop_test();
   end
endmodule : glitchfree_clock_mux_fanout_tb_top
